// file: rpc_pkg.sv
package rpc_pkg;

  // ==========================================================================
  // Command identifiers and outcome flags
  // ==========================================================================
  localparam logic [9:0] CMD_STANDBY = 10'd161;
  localparam logic [9:0] CMD_FIX_INTERVAL = 10'd220;
  localparam logic [9:0] CMD_FIX_INTERVAL_WR = 10'd300;
  localparam logic [9:0] CMD_EXTEND_RX = 10'd223;
  localparam logic [9:0] CMD_DUTY_CYCLE = 10'd225;
  localparam logic [9:0] CMD_BAUD = 10'd251;
  localparam logic [9:0] MSG_STARTUP = 10'd10;
  localparam logic [1:0] FLAG_INVALID = 2'd0;
  localparam logic [1:0] FLAG_UNSUPPORTED = 2'd1;
  localparam logic [1:0] FLAG_FAILED = 2'd2;
  localparam logic [1:0] FLAG_OK = 2'd3;

  // ==========================================================================
  // Field limits, modes and reset values
  // ==========================================================================
  localparam logic [31:0] FIX_MIN_MS = 32'd100;
  localparam logic [31:0] SATS_MIN = 32'd1;
  localparam logic [31:0] SATS_MAX = 32'd4;
  localparam logic [31:0] EXT_MIN_MS = 32'd40000;
  localparam logic [31:0] EXT_MAX_MS = 32'd180000;
  localparam logic [31:0] GAP_MAX_MS = 32'd3600000;
  localparam logic [7:0] MODE_NORMAL = 8'd0;
  localparam logic [7:0] MODE_DUTY = 8'd2;
  localparam logic [7:0] MODE_ADAPTIVE = 8'd8;
  localparam logic [16:0] BAUD_DEFAULT = 17'd9600;
  localparam logic [31:0] FIX_RESET_MS = 32'd1000;
  localparam logic [31:0] EXT_RESET_MS = 32'd180000;
  localparam logic [31:0] GAP_RESET_MS = 32'd60000;
  localparam logic [31:0] CYCLE_RESET_MS = 32'd1000;
  localparam logic [7:0] SNR_RESET = 8'd0;
  localparam logic [2:0] SATS_RESET = 3'd1;
  // Bits per character on the serial line, start and stop included.
  localparam logic [3:0] BITS_PER_CHAR = 4'd10;
  localparam logic [9:0] MS_PER_S = 10'd1000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [9:0] id;
    logic [2:0] nfields;
    logic has_cksum;
    logic terminated;
    logic [4:0][31:0] field;
  } rpc_cmd_t;

  typedef struct packed {
    logic [9:0] cmd;
    logic [1:0] flag;
  } rpc_ack_t;

  typedef enum logic [1:0] {
    PW_ON,
    PW_SLEEP,
    PW_STANDBY
  } rpc_power_t;

endpackage

// file: rpc_core.sv
`timescale 1ns/10ps
// Overview of operation
// (RQ1) Command 161 with zero enters standby.
// (RQ2) Any receive line transition wakes from standby.
// (RQ3) Startup sentence 010 precedes output after wake.
// (RQ4) Command 220 or 300 sets fix interval.
// (RQ5) Host supplies fix interval above 100 ms.
// (RQ6) Interval too short for output bandwidth: flag 2.
// (RQ7) Command 223 takes sats, snr, extend, gap.
// (RQ8) Extend when ephemeris sats below minimum 1..4.
// (RQ9) Ignore satellites below the SNR threshold.
// (RQ10) Extend on time 40000 to 180000 ms.
// (RQ11) Extend gap 0 to 3600000 ms.
// (RQ12) Duty mode alternates on and sleep autonomously.
// (RQ13) Mode 0 normal, 2 duty, 8 adaptive.
// (RQ14) Normal or cold-start on and off durations.
// (RQ15) Modes 0 and 8 need no timing fields.
// (RQ16) Command 251 sets listed baud, zero default.
// (RQ17) Acknowledge carries command and outcome flag.
// (RQ18) Sentences without checksum are rejected.
// (RQ19) Process only after CR LF terminator.
// (RQ20) Baud switches after acknowledgement completes.
// (RQ21) Out-of-range field: flag 0, config unchanged.
module rpc_core
  import rpc_pkg::*;
#(
  parameter int MS_CYC = rpc_pkg::MS_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire rpc_pkg::rpc_cmd_t CMD,
  output logic CMD_READY,
  output logic ACK_VALID,
  output rpc_pkg::rpc_ack_t ACK,
  input wire logic ACK_TAKEN,
  output logic STARTUP_REQ,
  input wire logic STARTUP_TAKEN,
  input wire logic RXD,
  input wire logic [15:0] MSG_BYTES,
  input wire logic [2:0] EPH_SATS,
  input wire logic COLD_START,
  output logic RX_ON,
  output logic STANDBY,
  output logic [16:0] BAUD_RATE,
  output logic [31:0] FIX_INTERVAL_MS,
  output logic [7:0] SNR_MIN,
  output logic [7:0] OP_MODE,
  output logic EXTENDING
);
  import rpc_pkg::*;

  if (MS_CYC < 1) begin : g_ms_cyc_check
    $error("MS_CYC must be at least one cycle");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    rpc_power_t pw;
    logic rxd;
    logic startup;
    logic ack_v;
    rpc_ack_t ack;
    logic baud_pend;
    logic [16:0] baud_new;
    logic [16:0] baud;
    logic [31:0] fix_ms;
    logic [2:0] min_sats;
    logic [7:0] snr;
    logic [31:0] ext_ms;
    logic [31:0] gap_ms;
    logic [7:0] mode;
    logic [31:0] on_ms;
    logic [31:0] off_ms;
    logic [31:0] cold_on;
    logic [31:0] cold_off;
    logic [31:0] pre;
    logic [31:0] ms;
    logic [31:0] gap_cnt;
    logic extend_on_ms;
    logic ready;
    logic rx_on;
    logic stby;
  } rpc_state_t;

  rpc_state_t s_q, s_d;

  function automatic logic baud_ok(input logic [31:0] r);
    return r == 32'd4800 || r == 32'd9600 || r == 32'd14400 || r == 32'd19200 ||
           r == 32'd38400 || r == 32'd57600 || r == 32'd115200;
  endfunction

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return v >= lo && v <= hi;
  endfunction

  logic take;
  logic [1:0] flag;
  logic [48:0] bits_avail;
  logic [48:0] bits_need;
  logic ms_tick;
  logic [31:0] on_len;
  logic [31:0] off_len;

  // A command is held off while an ack or the startup sentence is still owed.
  assign take = CMD_VALID && s_q.ready;
  // Capacity in bits per interval compared with the bits the enabled messages need.
  assign bits_avail = 49'(CMD.field[0]) * 49'(s_q.baud); // RQ6
  assign bits_need = 49'(MSG_BYTES) * 49'(BITS_PER_CHAR) * 49'(MS_PER_S); // RQ6
  assign ms_tick = s_q.pre == 32'(MS_CYC - 1);
  assign on_len = COLD_START ? s_q.cold_on : s_q.on_ms; // RQ14
  assign off_len = COLD_START ? s_q.cold_off : s_q.off_ms; // RQ14

  always_comb begin
    s_d = s_q;
    flag = FLAG_INVALID;
    s_d.rxd = RXD;

    // ========================================================================
    // Standby, wake and duty cycling
    // ========================================================================
    // This runs ahead of the command decode so that a command's power state wins.
    if (s_q.pw == PW_STANDBY) begin
      if (RXD != s_q.rxd) begin
        s_d.pw = PW_ON; // RQ2
        s_d.startup = 1'b1; // RQ3
        s_d.pre = 32'd0;
        s_d.ms = 32'd0;
      end
    end else begin
      s_d.pre = ms_tick ? 32'd0 : s_q.pre + 32'd1;
      if (ms_tick && s_q.gap_cnt != 32'hffffffff) begin
        s_d.gap_cnt = s_q.gap_cnt + 32'd1;
      end
      if (s_q.mode != MODE_DUTY) begin
        s_d.pw = PW_ON;
        s_d.extend_on_ms = 1'b0;
      end else if (ms_tick) begin // RQ12
        s_d.ms = s_q.ms + 32'd1;
        if (s_q.pw == PW_ON && s_q.extend_on_ms && s_q.ms + 32'd1 >= s_q.ext_ms) begin
          s_d.extend_on_ms = 1'b0;
          s_d.pw = PW_SLEEP;
          s_d.ms = 32'd0;
        end else if (s_q.pw == PW_ON && !s_q.extend_on_ms && s_q.ms + 32'd1 >= on_len) begin
          s_d.ms = 32'd0;
          if (EPH_SATS < s_q.min_sats && s_q.gap_cnt >= s_q.gap_ms) begin // RQ8
            s_d.extend_on_ms = 1'b1;
            s_d.gap_cnt = 32'd0; // RQ11
          end else begin
            s_d.pw = PW_SLEEP; // RQ12
          end
        end else if (s_q.pw == PW_SLEEP && s_q.ms + 32'd1 >= off_len) begin
          s_d.pw = PW_ON; // RQ12
          s_d.ms = 32'd0;
        end
      end
    end

    // ========================================================================
    // Command decode
    // ========================================================================
    if (take && CMD.terminated) begin // RQ19
      if (!CMD.has_cksum) begin
        flag = FLAG_INVALID; // RQ18
      end else if (CMD.id == CMD_STANDBY) begin
        if (CMD.nfields >= 3'd1 && CMD.field[0] == 32'd0) begin
          flag = FLAG_OK;
          s_d.pw = PW_STANDBY; // RQ1
        end
      end else if (CMD.id == CMD_FIX_INTERVAL || CMD.id == CMD_FIX_INTERVAL_WR) begin // RQ4
        // Intervals at or under the floor are refused here too, not only trusted.
        if (CMD.nfields >= 3'd1 && CMD.field[0] > FIX_MIN_MS) begin // RQ5 RQ21
          if (bits_avail < bits_need) begin
            flag = FLAG_FAILED; // RQ6
          end else begin
            flag = FLAG_OK;
            s_d.fix_ms = CMD.field[0]; // RQ4
          end
        end
      end else if (CMD.id == CMD_EXTEND_RX) begin
        if (CMD.nfields >= 3'd4 && in_range(CMD.field[0], SATS_MIN, SATS_MAX) && CMD.field[1] < 32'd256 &&
            in_range(CMD.field[2], EXT_MIN_MS, EXT_MAX_MS) && CMD.field[3] <= GAP_MAX_MS) begin // RQ8 RQ10 RQ11 RQ21
          flag = FLAG_OK;
          s_d.min_sats = CMD.field[0][2:0]; // RQ7
          s_d.snr = CMD.field[1][7:0];
          s_d.ext_ms = CMD.field[2];
          s_d.gap_ms = CMD.field[3];
        end
      end else if (CMD.id == CMD_DUTY_CYCLE) begin
        if (CMD.nfields >= 3'd1 && (CMD.field[0] == 32'(MODE_NORMAL) || CMD.field[0] == 32'(MODE_ADAPTIVE))) begin
          flag = FLAG_OK; // RQ15
          s_d.mode = CMD.field[0][7:0]; // RQ13
        end else if (CMD.nfields == 3'd5 && CMD.field[0] == 32'(MODE_DUTY) && CMD.field[1] != 32'd0 &&
                     CMD.field[3] != 32'd0) begin // RQ21
          flag = FLAG_OK;
          s_d.mode = MODE_DUTY; // RQ13
          s_d.on_ms = CMD.field[1]; // RQ14
          s_d.off_ms = CMD.field[2];
          s_d.cold_on = CMD.field[3];
          s_d.cold_off = CMD.field[4];
          s_d.pre = 32'd0;
          s_d.ms = 32'd0;
          s_d.pw = PW_ON;
        end
      end else if (CMD.id == CMD_BAUD) begin
        if (CMD.nfields >= 3'd1 && (CMD.field[0] == 32'd0 || baud_ok(CMD.field[0]))) begin // RQ16 RQ21
          flag = FLAG_OK;
          s_d.baud_pend = 1'b1; // RQ20
          s_d.baud_new = CMD.field[0] == 32'd0 ? BAUD_DEFAULT : CMD.field[0][16:0];
        end
      end else begin
        flag = FLAG_UNSUPPORTED;
      end
      s_d.ack_v = 1'b1; // RQ17
      s_d.ack.cmd = CMD.id;
      s_d.ack.flag = flag;
    end

    // ========================================================================
    // Acknowledge hand-off; a new rate only applies once the old-rate ack left.
    // ========================================================================
    if (s_q.ack_v && ACK_TAKEN) begin
      s_d.ack_v = 1'b0;
      if (s_q.baud_pend) begin
        s_d.baud_pend = 1'b0;
        s_d.baud = s_q.baud_new; // RQ20
      end
    end

    if (s_q.startup && STARTUP_TAKEN) begin
      s_d.startup = 1'b0;
    end
    // Decoded outputs are registered so that none of them leaves through logic.
    s_d.ready = !s_d.ack_v && !s_d.startup && s_d.pw != PW_STANDBY;
    s_d.rx_on = s_d.pw == PW_ON;
    s_d.stby = s_d.pw == PW_STANDBY;
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_q <= '{pw: PW_ON, rxd: 1'b1, startup: 1'b0, ack_v: 1'b0, ack: '0, baud_pend: 1'b0,
               baud_new: BAUD_DEFAULT, baud: BAUD_DEFAULT, fix_ms: FIX_RESET_MS, min_sats: SATS_RESET,
               snr: SNR_RESET, ext_ms: EXT_RESET_MS, gap_ms: GAP_RESET_MS, mode: MODE_NORMAL,
               on_ms: CYCLE_RESET_MS, off_ms: CYCLE_RESET_MS, cold_on: CYCLE_RESET_MS,
               cold_off: CYCLE_RESET_MS, pre: 32'd0, ms: 32'd0, gap_cnt: 32'hffffffff, extend_on_ms: 1'b0, ready: 1'b1,
               rx_on: 1'b1, stby: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  // ==========================================================================
  assign CMD_READY = s_q.ready;
  assign ACK_VALID = s_q.ack_v; // RQ17
  assign ACK = s_q.ack;
  assign STARTUP_REQ = s_q.startup; // RQ3
  assign RX_ON = s_q.rx_on;
  assign STANDBY = s_q.stby;
  assign BAUD_RATE = s_q.baud;
  assign FIX_INTERVAL_MS = s_q.fix_ms;
  // The tracker uses this to drop weak satellites from the ephemeris wait.
  assign SNR_MIN = s_q.snr; // RQ9
  assign OP_MODE = s_q.mode;
  assign EXTENDING = s_q.extend_on_ms;

endmodule

// file: rpc_core_asserts.sv
`timescale 1ns/10ps
module rpc_core_asserts
  import rpc_pkg::*;
#(
  parameter int MS_CYC = 10
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire rpc_pkg::rpc_cmd_t CMD,
  input wire logic CMD_READY,
  input wire logic ACK_VALID,
  input wire rpc_pkg::rpc_ack_t ACK,
  input wire logic ACK_TAKEN,
  input wire logic STARTUP_REQ,
  input wire logic STARTUP_TAKEN,
  input wire logic RXD,
  input wire logic [15:0] MSG_BYTES,
  input wire logic STANDBY,
  input wire logic RX_ON,
  input wire logic [16:0] BAUD_RATE,
  input wire logic [7:0] SNR_MIN,
  input wire logic [7:0] OP_MODE
);
  import rpc_pkg::*;

  // ==========================================================================
  // Command outcome and power state checks
  // ==========================================================================
  logic tk;
  logic [31:0] f0;
  assign tk = CMD_VALID && CMD_READY && CMD.terminated && CMD.has_cksum;
  assign f0 = CMD.field[0];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  a_ack_echo: assert property (CMD_VALID && CMD_READY && CMD.terminated |=> ACK_VALID && ACK.cmd == $past(CMD.id))
    else $error("ack missing or wrong command");
  a_silent_unterm: assert property (CMD_VALID && CMD_READY && !CMD.terminated |=> !ACK_VALID)
    else $error("ack for unterminated sentence");
  a_cksum_reject: assert property (CMD_VALID && CMD_READY && CMD.terminated && !CMD.has_cksum |=> ACK.flag == FLAG_INVALID)
    else $error("missing checksum accepted");
  a_standby_entry: assert property (tk && CMD.id == CMD_STANDBY && CMD.nfields != 0 && f0 == 0 |=> STANDBY && !RX_ON)
    else $error("standby not entered");
  a_wake_startup: assert property (STANDBY && RXD != $past(RXD) |=> !STANDBY && RX_ON && STARTUP_REQ)
    else $error("no wake on receive activity");
  a_startup_hold: assert property (STARTUP_REQ && !STARTUP_TAKEN |=> STARTUP_REQ && !CMD_READY)
    else $error("startup sentence overtaken");
  a_fix_bw: assert property (tk && CMD.id == CMD_FIX_INTERVAL && CMD.nfields != 0 && f0 > FIX_MIN_MS
    && 64'(f0) * BAUD_RATE < 64'(MSG_BYTES) * 64'd10000 |=> ACK.flag == FLAG_FAILED)
    else $error("short interval not failed");
  a_sats_range: assert property (tk && CMD.id == CMD_EXTEND_RX && (f0 == 0 || f0 > SATS_MAX)
    |=> ACK.flag == FLAG_INVALID && $stable(SNR_MIN))
    else $error("satellite minimum out of range accepted");
  a_baud_hold: assert property (ACK_VALID && !ACK_TAKEN |=> $stable(BAUD_RATE))
    else $error("baud changed before ack sent");
  a_mode_normal: assert property (tk && CMD.id == CMD_DUTY_CYCLE && CMD.nfields != 0 && f0 == 0
    |=> OP_MODE == MODE_NORMAL && ACK.flag == FLAG_OK)
    else $error("normal mode not taken");
endmodule

bind rpc_core rpc_core_asserts #(.MS_CYC(MS_CYC)) rpc_core_asserts_i (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .ACK_VALID(ACK_VALID), .ACK(ACK), .ACK_TAKEN(ACK_TAKEN),
  .STARTUP_REQ(STARTUP_REQ), .STARTUP_TAKEN(STARTUP_TAKEN), .RXD(RXD), .MSG_BYTES(MSG_BYTES), .STANDBY(STANDBY),
  .RX_ON(RX_ON), .BAUD_RATE(BAUD_RATE), .SNR_MIN(SNR_MIN), .OP_MODE(OP_MODE));

// file: rpc_host.sv
`timescale 1ns/10ps
module rpc_host (
  input wire logic clk,
  input wire logic ack_valid,
  input wire logic startup_req,
  input wire logic [3:0] lag,
  output logic ack_taken = 1'b0,
  output logic startup_taken = 1'b0
);
  // ==========================================================================
  // Host transmit side: finishes each pending output after lag cycles
  // ==========================================================================
  // A one-cycle pulse per output; the idle cycle after it keeps one output from being taken twice.
  logic [3:0] cnt = 4'h0;
  always @(posedge clk) begin
    if (ack_taken || startup_taken || !(ack_valid || startup_req)) begin
      cnt <= 4'h0;
      ack_taken <= 1'b0;
      startup_taken <= 1'b0;
    end else if (cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else begin
      ack_taken <= ack_valid;
      startup_taken <= startup_req;
    end
  end
endmodule

// file: test_receiver_power_rate_commands.sv
`timescale 1ns/10ps
module test_receiver_power_rate_commands;
  import rpc_pkg::*;
  typedef struct {rpc_cmd_t c; logic [1:0] fl;} rpc_row_t;
  logic CLK_SYS = 0, NRST = 0, CMD_VALID = 0, RXD = 1, COLD_START = 0;
  logic CMD_READY, ACK_VALID, ACK_TAKEN, STARTUP_REQ, STARTUP_TAKEN, RX_ON, STANDBY, EXTENDING;
  rpc_cmd_t CMD = '0;
  rpc_ack_t ACK;
  logic [15:0] MSG_BYTES = 16'h64;
  logic [2:0] EPH_SATS = 3'h4;
  logic [3:0] lag = 4'h0;
  logic [16:0] BAUD_RATE, pb;
  logic [31:0] FIX_INTERVAL_MS;
  logic [7:0] SNR_MIN, OP_MODE;
  logic [16:0] rates[7] = '{17'h12c0, 17'h2580, 17'h3840, 17'h4b00, 17'h9600, 17'he100, 17'h1c200};
  int n_errors = 0, check_count = 0;
  rpc_row_t rows[$];
  rpc_cmd_t c;
  always #5 CLK_SYS = ~CLK_SYS;
  // Ten cycles per millisecond keeps the duty-cycle phases short.
  rpc_core #(.MS_CYC(10)) rpc_core_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .ACK_VALID(ACK_VALID), .ACK(ACK), .ACK_TAKEN(ACK_TAKEN), .STARTUP_REQ(STARTUP_REQ),
    .STARTUP_TAKEN(STARTUP_TAKEN), .RXD(RXD), .MSG_BYTES(MSG_BYTES), .EPH_SATS(EPH_SATS), .COLD_START(COLD_START),
    .RX_ON(RX_ON), .STANDBY(STANDBY), .BAUD_RATE(BAUD_RATE), .FIX_INTERVAL_MS(FIX_INTERVAL_MS), .SNR_MIN(SNR_MIN),
    .OP_MODE(OP_MODE), .EXTENDING(EXTENDING));
  rpc_host rpc_host_i (.clk(CLK_SYS), .ack_valid(ACK_VALID), .startup_req(STARTUP_REQ), .lag(lag),
    .ack_taken(ACK_TAKEN), .startup_taken(STARTUP_TAKEN));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Every sentence built here carries a checksum and the terminator pair.
  function automatic rpc_cmd_t mk(logic [9:0] i, logic [2:0] n, logic [31:0] a, b = 0, c = 0, d = 0, e = 0);
    return '{i, n, 1'b1, 1'b1, {e, d, c, b, a}};
  endfunction
  function automatic logic sig(int s);
    case (s)
      0: return ACK_VALID;
      1: return STARTUP_REQ;
      2: return RX_ON;
      3: return EXTENDING;
      default: return CMD_READY;
    endcase
  endfunction
  task automatic chk(logic [63:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Sampling at the falling edge keeps reads clear of the launching rising edge.
  task automatic wt(int s, logic v, int lim);
    int i = 0;
    do begin
      @(negedge CLK_SYS);
      i++;
    end while (sig(s) !== v && i < lim);
    chk(sig(s), v);
    if (sig(s) !== v) end_sim();
  endtask
  task automatic send(rpc_cmd_t x);
    @(posedge CLK_SYS);
    CMD <= x;
    CMD_VALID <= 1'b1;
    wt(4, 1'b1, 60);
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b0;
  endtask
  task automatic run(rpc_cmd_t x, logic [1:0] fl);
    send(x);
    wt(0, 1'b1, 20);
    chk(ACK, {x.id, fl});
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rows = '{
      '{mk(CMD_FIX_INTERVAL, 3'h1, 32'h3e8), FLAG_OK},
      '{mk(CMD_FIX_INTERVAL, 3'h1, FIX_MIN_MS), FLAG_INVALID},
      '{mk(CMD_FIX_INTERVAL, 3'h1, 32'h68), FLAG_FAILED},
      '{mk(CMD_FIX_INTERVAL_WR, 3'h1, 32'h69), FLAG_OK},
      '{mk(CMD_EXTEND_RX, 3'h4, 32'h1, 32'h1e, EXT_MAX_MS, GAP_MAX_MS), FLAG_OK},
      '{mk(CMD_EXTEND_RX, 3'h4, SATS_MAX, 32'h14, EXT_MIN_MS, 32'h0), FLAG_OK},
      '{mk(CMD_EXTEND_RX, 3'h4, 32'h5, 32'h1e, EXT_MIN_MS, 32'h0), FLAG_INVALID},
      '{mk(CMD_EXTEND_RX, 3'h4, 32'h0, 32'h1e, EXT_MIN_MS, 32'h0), FLAG_INVALID},
      '{mk(CMD_EXTEND_RX, 3'h4, SATS_MAX, 32'h1e, EXT_MIN_MS - 32'h1, 32'h0), FLAG_INVALID},
      '{mk(CMD_EXTEND_RX, 3'h4, SATS_MAX, 32'h1e, EXT_MAX_MS + 32'h1, 32'h0), FLAG_INVALID},
      '{mk(CMD_EXTEND_RX, 3'h4, SATS_MAX, 32'h1e, EXT_MIN_MS, GAP_MAX_MS + 32'h1), FLAG_INVALID},
      '{mk(CMD_DUTY_CYCLE, 3'h1, 32'h0), FLAG_OK},
      '{mk(CMD_DUTY_CYCLE, 3'h1, 32'h8), FLAG_OK},
      '{mk(CMD_DUTY_CYCLE, 3'h1, 32'h2), FLAG_INVALID},
      '{mk(CMD_BAUD, 3'h1, 32'h4b0), FLAG_INVALID},
      '{mk(10'h3e7, 3'h0, 32'h0), FLAG_UNSUPPORTED},
      '{mk(CMD_BAUD, 3'h1, 32'h0), FLAG_OK}};
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    foreach (rows[k]) begin
      lag <= 4'(k % 4);
      run(rows[k].c, rows[k].fl);
    end
    wt(0, 1'b0, 20);
    chk(BAUD_RATE, BAUD_DEFAULT);
    chk(FIX_INTERVAL_MS, 32'h69);
    chk(SNR_MIN, 8'h14);
    chk(OP_MODE, MODE_ADAPTIVE);
    $display("table done");
    lag <= 4'h3;
    pb = BAUD_DEFAULT;
    foreach (rates[k]) begin
      run(mk(CMD_BAUD, 3'h1, 32'(rates[k])), FLAG_OK);
      chk(BAUD_RATE, pb);
      wt(0, 1'b0, 20);
      chk(BAUD_RATE, rates[k]);
      pb = rates[k];
    end
    run(mk(CMD_FIX_INTERVAL, 3'h1, 32'h65), FLAG_OK);
    c = mk(CMD_FIX_INTERVAL, 3'h1, 32'h3e8);
    c.has_cksum = 1'b0;
    run(c, FLAG_INVALID);
    c.terminated = 1'b0;
    c.has_cksum = 1'b1;
    send(c);
    repeat (5) @(negedge CLK_SYS);
    chk(ACK_VALID, 1'b0);
    chk(FIX_INTERVAL_MS, 32'h65);
    $display("baud and sentence checks done");
    run(mk(CMD_STANDBY, 3'h1, 32'h0), FLAG_OK);
    chk({STANDBY, RX_ON}, 2'b10);
    wt(0, 1'b0, 20);
    repeat (3) @(negedge CLK_SYS);
    chk(STANDBY, 1'b1);
    @(posedge CLK_SYS);
    RXD <= 1'b0;
    wt(1, 1'b1, 5);
    chk({STANDBY, ACK_VALID}, 2'b00);
    wt(1, 1'b0, 20);
    $display("standby done");
    run(mk(CMD_DUTY_CYCLE, 3'h5, 32'h2, 32'h3, 32'h2, 32'h3, 32'h5), FLAG_OK);
    wt(2, 1'b0, 60);
    wt(2, 1'b1, 40);
    chk(EXTENDING, 1'b0);
    @(posedge CLK_SYS);
    COLD_START <= 1'b1;
    wt(2, 1'b0, 60);
    // A normal sleep would end after 20 cycles; the cold sleep lasts 50.
    repeat (25) @(negedge CLK_SYS);
    chk(RX_ON, 1'b0);
    wt(2, 1'b1, 40);
    @(posedge CLK_SYS);
    COLD_START <= 1'b0;
    EPH_SATS <= 3'h0;
    wt(3, 1'b1, 80);
    chk(RX_ON, 1'b1);
    $display("duty cycle done");
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    @(negedge CLK_SYS);
    chk({BAUD_RATE, FIX_INTERVAL_MS}, {BAUD_DEFAULT, FIX_RESET_MS});
    chk({OP_MODE, SNR_MIN}, {MODE_NORMAL, SNR_RESET});
    chk({EXTENDING, RX_ON, STANDBY, ACK_VALID, STARTUP_REQ, CMD_READY}, 6'b010001);
    @(posedge CLK_SYS);
    NRST <= 1'b1;
    // The default rate is back, so an interval that would pass at the fast rate fails again.
    run(mk(CMD_FIX_INTERVAL, 3'h1, 32'h68), FLAG_FAILED);
    $display("reset done");
    end_sim();
  end
endmodule
